// *** pkg/can_store_defines.vh ***
`ifndef CAN_STORE_DEFINES_VH
`define CAN_STORE_DEFINES_VH

// ==========================================================
// register byte offsets
`define A_RETRY    8'h00
`define A_STATUS   8'h04
`define A_CAUSE    8'h08
`define A_CMD      8'h0C
`define A_OBJ_ID   8'h10
`define A_OBJ_MASK 8'h14
`define A_OBJ_CTRL 8'h18
`define A_DATA_LO  8'h1C
`define A_DATA_HI  8'h20
`define A_TXPEND   8'h24
`define A_FRESH    8'h28
`define A_VALID    8'h2C
`define A_INTPEND  8'h30

// ==========================================================
// command register fields
`define CMD_OBJ_HI 5
`define CMD_OP_HI  9
`define CMD_OP_LO  8
`define CMD_CLRINT 12
`define OP_SET     2'h1
`define OP_GET     2'h2
`define OP_CLEAR   2'h3
`define NUM_OBJ    6'h20

// ==========================================================
// object control fields
`define OC_TYPE_HI 2
`define OC_TXIE    3
`define OC_RXIE    4
`define OC_MSKE    5
`define OC_EXT     6
`define OC_DLC_HI  11
`define OC_DLC_LO  8
`define OC_FRESH   12
`define OC_LOST    13

// ==========================================================
// object types
`define TYPE_DATA_TX    3'h0
`define TYPE_REQ_TX     3'h1
`define TYPE_DATA_RX    3'h2
`define TYPE_REQ_RX     3'h3
`define TYPE_REQ_REPLY  3'h4

// ==========================================================
// status fields and codes
`define ST_TXOK    3
`define ST_RXOK    4
`define ST_EPASS   5
`define ST_EWARN   6
`define ST_BUSOFF  7
`define LEC_NONE   3'h0
`define LEC_STUFF  3'h1
`define LEC_FORM   3'h2
`define LEC_ACK    3'h3
`define LEC_BIT1   3'h4
`define LEC_BIT0   3'h5
`define LEC_CRC    3'h6
`define EWARN_LIMIT 8'h60
`define CAUSE_STATUS 32'h0000_8000
`define RETRY_RESET 1'b1

`endif

// *** core/can_message_object_store.v ***
`timescale 1ns/1ps
`include "can_store_defines.vh"

module can_message_object_store (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output reg pslverr_out,
  input wire rx_valid_in,
  input wire [28:0] rx_id_in,
  input wire rx_ext_in,
  input wire rx_rtr_in,
  input wire [3:0] rx_dlc_in,
  input wire [63:0] rx_data_in,
  output reg tx_valid_out,
  output reg [28:0] tx_id_out,
  output reg tx_ext_out,
  output reg tx_rtr_out,
  output reg [3:0] tx_dlc_out,
  output reg [63:0] tx_data_out,
  input wire tx_done_in,
  input wire tx_fail_in,
  output wire auto_retry_out,
  input wire bit_strobe_in,
  input wire bit_sent_in,
  input wire bit_seen_in,
  input wire err_strobe_in,
  input wire [2:0] err_code_in,
  input wire [7:0] tx_err_count_in,
  input wire [7:0] rx_err_count_in,
  input wire bus_off_in,
  input wire error_passive_in
);

  // ==========================================================
  // helpers
  // lowest set bit wins; bit 5 of the result flags an empty vector
  function [5:0] first_set;
    input [31:0] v;
    integer k;
    reg [5:0] n;
    begin
      first_set = 6'h20;
      n = 6'h00;
      for (k = 0; k < 32; k = k + 1) begin
        if (v[k] && first_set[5])
          first_set = n;
        n = n + 6'h01;
      end
    end
  endfunction

  // ==========================================================
  // object storage
  reg [28:0] id_mem [0:31];
  reg [28:0] mask_mem [0:31];
  reg [2:0] type_mem [0:31];
  reg [31:0] txie_mem;
  reg [31:0] rxie_mem;
  reg [31:0] mske_mem;
  reg [31:0] ext_mem;
  reg [3:0] dlc_mem [0:31];
  reg [63:0] data_mem [0:31];
  reg [31:0] object_valid_bit;
  reg [31:0] tx_pending_bit;
  reg [31:0] fresh_frame_bit;
  reg [31:0] lost_bit;
  reg [31:0] int_pending_bit;

  // staging registers, loaded by software or by an object read
  reg [28:0] stg_id;
  reg [28:0] stg_mask;
  reg [13:0] stg_ctrl;
  reg [63:0] stg_data;

  reg auto_retry;
  reg status_int;
  reg receive_success_flag;
  reg transmit_success_flag;
  reg [2:0] last_error_code_field;
  reg tx_busy;
  reg [4:0] tx_obj;

  wire error_warning_flag;
  wire error_passive_flag;

  // ==========================================================
  // apb decode
  wire wr_acc = psel_in & penable_in & pwrite_in;
  wire rd_acc = psel_in & penable_in & ~pwrite_in;
  wire setup = psel_in & ~penable_in;
  wire cmd_wr = wr_acc & (paddr_in == `A_CMD);
  wire stat_rd = rd_acc & (paddr_in == `A_STATUS);
  wire [5:0] cmd_num = pwdata_in[`CMD_OBJ_HI:0];
  wire [5:0] cmd_m1 = cmd_num - 6'h01;
  wire [4:0] cmd_idx = cmd_m1[4:0];
  wire cmd_ok = (cmd_num != 6'h00) && (cmd_num <= `NUM_OBJ);
  wire [1:0] cmd_op = pwdata_in[`CMD_OP_HI:`CMD_OP_LO];
  wire [2:0] stg_type = stg_ctrl[`OC_TYPE_HI:0];
  wire [31:0] clr_now = (cmd_wr && cmd_ok && cmd_op == `OP_CLEAR) ?
                        (32'h0000_0001 << cmd_idx) : 32'h0000_0000;

  // zero wait states; read data is latched in the setup cycle
  assign pready_out = 1'b1;
  assign auto_retry_out = auto_retry;
  assign error_warning_flag = (tx_err_count_in >= `EWARN_LIMIT) |
                              (rx_err_count_in >= `EWARN_LIMIT);
  assign error_passive_flag = error_passive_in;

  // ==========================================================
  // acceptance filtering
  reg [31:0] rx_match;
  reg [28:0] m;
  reg type_ok;
  integer i;
  always @* begin
    rx_match = 32'h0000_0000;
    m = 29'h0000_0000;
    type_ok = 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
      if (rx_rtr_in)
        type_ok = (type_mem[i] == `TYPE_REQ_RX) ||
                  (type_mem[i] == `TYPE_REQ_REPLY);
      else
        type_ok = (type_mem[i] == `TYPE_DATA_RX);
      m = mske_mem[i] ? mask_mem[i] : 29'h1FFF_FFFF;
      rx_match[i] = object_valid_bit[i] & ~clr_now[i] & type_ok &
                    (ext_mem[i] == rx_ext_in) &
                    ((rx_id_in & m) == id_mem[i]);
    end
  end

  wire [5:0] rx_first = first_set(rx_match);
  wire rx_hit = rx_valid_in & ~rx_first[5];
  wire [4:0] rx_idx = rx_first[4:0];
  wire [5:0] tx_first = first_set(tx_pending_bit & object_valid_bit);
  wire [5:0] int_first = first_set(int_pending_bit);
  wire [5:0] int_num = int_first + 6'h01;
  wire [31:0] cause = status_int ? `CAUSE_STATUS :
                      int_first[5] ? 32'h0000_0000 :
                      {26'h000_0000, int_num};

  // bit monitor: 1 means recessive on the line
  wire bit1_err = bit_strobe_in & bit_sent_in & ~bit_seen_in;
  wire bit0_err = bit_strobe_in & ~bit_sent_in & bit_seen_in;

  // ==========================================================
  // read mux
  reg [31:0] next_rdata;
  reg next_err;
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr_in)
      `A_RETRY: next_rdata = {31'h0000_0000, auto_retry};
      `A_STATUS: next_rdata = {24'h00_0000, bus_off_in,
                               error_warning_flag, error_passive_flag,
                               receive_success_flag,
                               transmit_success_flag,
                               last_error_code_field};
      `A_CAUSE: next_rdata = cause;
      `A_CMD: next_rdata = 32'h0000_0000;
      `A_OBJ_ID: next_rdata = {3'h0, stg_id};
      `A_OBJ_MASK: next_rdata = {3'h0, stg_mask};
      `A_OBJ_CTRL: next_rdata = {18'h0_0000, stg_ctrl};
      `A_DATA_LO: next_rdata = stg_data[31:0];
      `A_DATA_HI: next_rdata = stg_data[63:32];
      `A_TXPEND: next_rdata = tx_pending_bit;
      `A_FRESH: next_rdata = fresh_frame_bit;
      `A_VALID: next_rdata = object_valid_bit;
      `A_INTPEND: next_rdata = int_pending_bit;
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (setup) begin
      prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
      pslverr_out <= next_err;
    end
  end

  // ==========================================================
  // object arrays (no reset: contents defined by a set command)
  always @(posedge clk_sys_in) begin
    if (cmd_wr && cmd_ok && cmd_op == `OP_SET) begin
      id_mem[cmd_idx] <= stg_ctrl[`OC_EXT] ? stg_id :
                         {18'h0_0000, stg_id[10:0]};
      mask_mem[cmd_idx] <= stg_mask;
      type_mem[cmd_idx] <= stg_type;
      dlc_mem[cmd_idx] <= stg_ctrl[`OC_DLC_HI:`OC_DLC_LO];
      data_mem[cmd_idx] <= stg_data;
    end
    if (rx_hit && !rx_rtr_in) begin
      dlc_mem[rx_idx] <= rx_dlc_in;
      data_mem[rx_idx] <= rx_data_in;
    end
    if (tx_busy && tx_done_in && type_mem[tx_obj] == `TYPE_REQ_TX)
      type_mem[tx_obj] <= `TYPE_DATA_RX;
  end

  // ==========================================================
  // staging registers and per-object enables
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stg_id <= 29'h0000_0000;
      stg_mask <= 29'h0000_0000;
      stg_ctrl <= 14'h0000;
      stg_data <= 64'h0000_0000_0000_0000;
      auto_retry <= `RETRY_RESET;
      txie_mem <= 32'h0000_0000;
      rxie_mem <= 32'h0000_0000;
      mske_mem <= 32'h0000_0000;
      ext_mem <= 32'h0000_0000;
    end else begin
      if (wr_acc) begin
        case (paddr_in)
          `A_RETRY: auto_retry <= pwdata_in[0];
          `A_OBJ_ID: stg_id <= pwdata_in[28:0];
          `A_OBJ_MASK: stg_mask <= pwdata_in[28:0];
          `A_OBJ_CTRL: stg_ctrl <= {2'h0, pwdata_in[11:0]};
          `A_DATA_LO: stg_data[31:0] <= pwdata_in;
          `A_DATA_HI: stg_data[63:32] <= pwdata_in;
          default: stg_ctrl <= stg_ctrl;
        endcase
      end
      if (cmd_wr && cmd_ok && cmd_op == `OP_SET) begin
        txie_mem[cmd_idx] <= stg_ctrl[`OC_TXIE];
        rxie_mem[cmd_idx] <= stg_ctrl[`OC_RXIE];
        mske_mem[cmd_idx] <= stg_ctrl[`OC_MSKE];
        ext_mem[cmd_idx] <= stg_ctrl[`OC_EXT];
      end
      if (cmd_wr && cmd_ok && cmd_op == `OP_GET) begin
        stg_id <= id_mem[cmd_idx];
        stg_mask <= mask_mem[cmd_idx];
        stg_ctrl <= {lost_bit[cmd_idx], fresh_frame_bit[cmd_idx],
                     dlc_mem[cmd_idx], 1'b0, ext_mem[cmd_idx],
                     mske_mem[cmd_idx], rxie_mem[cmd_idx],
                     txie_mem[cmd_idx], type_mem[cmd_idx]};
        stg_data <= data_mem[cmd_idx];
      end
    end
  end

  // ==========================================================
  // flags, status and transmit scheduling
  // hardware sets come after software clears so a same-cycle event wins, except against a clear command
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      object_valid_bit <= 32'h0000_0000;
      tx_pending_bit <= 32'h0000_0000;
      fresh_frame_bit <= 32'h0000_0000;
      lost_bit <= 32'h0000_0000;
      int_pending_bit <= 32'h0000_0000;
      status_int <= 1'b0;
      receive_success_flag <= 1'b0;
      transmit_success_flag <= 1'b0;
      last_error_code_field <= `LEC_NONE;
      tx_busy <= 1'b0;
      tx_obj <= 5'h00;
      tx_valid_out <= 1'b0;
      tx_id_out <= 29'h0000_0000;
      tx_ext_out <= 1'b0;
      tx_rtr_out <= 1'b0;
      tx_dlc_out <= 4'h0;
      tx_data_out <= 64'h0000_0000_0000_0000;
    end else begin
      if (cmd_wr && cmd_ok) begin
        case (cmd_op)
          `OP_SET: begin
            object_valid_bit[cmd_idx] <= 1'b1;
            tx_pending_bit[cmd_idx] <= (stg_type == `TYPE_DATA_TX) ||
                                       (stg_type == `TYPE_REQ_TX);
            fresh_frame_bit[cmd_idx] <= 1'b0;
            lost_bit[cmd_idx] <= 1'b0;
            int_pending_bit[cmd_idx] <= 1'b0;
          end
          `OP_GET: begin
            fresh_frame_bit[cmd_idx] <= 1'b0;
            lost_bit[cmd_idx] <= 1'b0;
            if (pwdata_in[`CMD_CLRINT])
              int_pending_bit[cmd_idx] <= 1'b0;
          end
          `OP_CLEAR: begin
            object_valid_bit[cmd_idx] <= 1'b0;
            tx_pending_bit[cmd_idx] <= 1'b0;
            fresh_frame_bit[cmd_idx] <= 1'b0;
            lost_bit[cmd_idx] <= 1'b0;
            int_pending_bit[cmd_idx] <= 1'b0;
          end
          default: status_int <= status_int;
        endcase
      end
      if (stat_rd) begin
        status_int <= 1'b0;
        receive_success_flag <= 1'b0;
        transmit_success_flag <= 1'b0;
      end
      // transmit side: one frame in flight, lowest object first
      if (tx_busy) begin
        if (tx_done_in) begin
          tx_busy <= 1'b0;
          tx_valid_out <= 1'b0;
          transmit_success_flag <= 1'b1;
          status_int <= 1'b1;
          if (object_valid_bit[tx_obj] && !clr_now[tx_obj]) begin
            tx_pending_bit[tx_obj] <= 1'b0;
            if (txie_mem[tx_obj])
              int_pending_bit[tx_obj] <= 1'b1;
          end
        end else if (tx_fail_in) begin
          tx_busy <= 1'b0;
          tx_valid_out <= 1'b0;
          // without retry the request is dropped after one attempt
          if (!auto_retry)
            tx_pending_bit[tx_obj] <= 1'b0;
        end
      end else if (!tx_first[5]) begin
        tx_busy <= 1'b1;
        tx_obj <= tx_first[4:0];
        tx_valid_out <= 1'b1;
        tx_id_out <= id_mem[tx_first[4:0]];
        tx_ext_out <= ext_mem[tx_first[4:0]];
        tx_rtr_out <= (type_mem[tx_first[4:0]] == `TYPE_REQ_TX);
        tx_dlc_out <= dlc_mem[tx_first[4:0]];
        tx_data_out <= data_mem[tx_first[4:0]];
      end
      // receive side
      if (rx_valid_in) begin
        receive_success_flag <= 1'b1;
        status_int <= 1'b1;
      end
      if (rx_hit) begin
        fresh_frame_bit[rx_idx] <= 1'b1;
        lost_bit[rx_idx] <= fresh_frame_bit[rx_idx] |
                            lost_bit[rx_idx];
        if (rxie_mem[rx_idx])
          int_pending_bit[rx_idx] <= 1'b1;
        if (type_mem[rx_idx] == `TYPE_REQ_REPLY)
          tx_pending_bit[rx_idx] <= 1'b1;
      end
      // error capture, bit monitor has priority
      if (bit1_err) begin
        last_error_code_field <= `LEC_BIT1;
        status_int <= 1'b1;
      end else if (bit0_err) begin
        last_error_code_field <= `LEC_BIT0;
        status_int <= 1'b1;
      end else if (err_strobe_in) begin
        last_error_code_field <= err_code_in;
        status_int <= 1'b1;
      end
    end
  end

endmodule

// *** tb/can_store_props.sv ***
`timescale 1ns/1ps
`include "can_store_defines.vh"
module can_store_props (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire tx_valid_out,
  input wire [28:0] tx_id_out,
  input wire [63:0] tx_data_out,
  input wire tx_done_in,
  input wire tx_fail_in,
  input wire auto_retry_out,
  input wire [7:0] tx_err_count_in,
  input wire [7:0] rx_err_count_in,
  input wire bus_off_in,
  input wire error_passive_in
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  wire setup = psel_in && !penable_in;
  wire hole = paddr_in[1:0] != 2'h0 || paddr_in > `A_INTPEND;
  wire answer = tx_done_in || tx_fail_in;
  wire warn = tx_err_count_in >= `EWARN_LIMIT ||
    rx_err_count_in >= `EWARN_LIMIT;
  // ==========================================================
  // steps
  sequence s_gap;
    !tx_valid_out ##[1:2] tx_valid_out;
  endsequence
  sequence s_status_rd;
    setup && !pwrite_in && paddr_in == `A_STATUS;
  endsequence
  // ==========================================================
  // checks
  a_ready_high: assert property (pready_out)
    else $error("pready low");
  a_hole_err: assert property (setup && hole |=> pslverr_out)
    else $error("unmapped access not refused");
  a_map_ok: assert property (setup && !hole |=> !pslverr_out)
    else $error("mapped access refused");
  a_tx_hold: assert property (
    tx_valid_out && !answer |=> tx_valid_out && $stable(tx_id_out) &&
    $stable(tx_data_out))
    else $error("offered frame changed");
  a_tx_drop: assert property (tx_valid_out && answer |=> !tx_valid_out)
    else $error("offer kept after answer");
  a_retry_gap: assert property (
    tx_valid_out && tx_fail_in && auto_retry_out |=> s_gap)
    else $error("no relaunch after failure");
  a_retry_rst: assert property ($rose(rstn_in) |-> auto_retry_out)
    else $error("retry not on after reset");
  a_status_live: assert property (s_status_rd |=>
    prdata_out[7:5] == {$past(bus_off_in), $past(warn),
    $past(error_passive_in)})
    else $error("status flags wrong");
endmodule

bind can_message_object_store can_store_props u_can_store_props (
  .clk_sys_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .prdata_out, .pready_out, .pslverr_out, .tx_valid_out, .tx_id_out,
  .tx_data_out, .tx_done_in, .tx_fail_in, .auto_retry_out,
  .tx_err_count_in, .rx_err_count_in, .bus_off_in, .error_passive_in);

// *** tb/can_bus_partner.sv ***
`timescale 1ns/1ps
module can_bus_partner #(
  parameter WAIT = 4'h6
) (
  input wire clk_sys_in,
  input wire rstn_in,
  input wire tx_valid_in,
  input wire fail_mode_in,
  output reg tx_done_out,
  output reg tx_fail_out,
  output reg rx_valid_out = 1'h0,
  output reg [28:0] rx_id_out = 29'h0,
  output reg rx_ext_out = 1'h0,
  output reg rx_rtr_out = 1'h0,
  output reg [3:0] rx_dlc_out = 4'h0,
  output reg [63:0] rx_data_out = 64'h0
);
  reg [3:0] busy;
  // ==========================================================
  // send answers
  always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy <= 4'h0;
      tx_done_out <= 1'h0;
      tx_fail_out <= 1'h0;
    end else begin
      tx_done_out <= 1'h0;
      tx_fail_out <= 1'h0;
      // the offer is still up in the cycle of an answer: skip it
      if (tx_valid_in && !tx_done_out && !tx_fail_out) begin
        busy <= (busy == WAIT) ? 4'h0 : busy + 4'h1;
        if (busy == WAIT) begin
          tx_done_out <= !fail_mode_in;
          tx_fail_out <= fail_mode_in;
        end
      end
    end
  end
  // ==========================================================
  // frames from other nodes
  task send(input [28:0] id, input ext, input rtr, input [3:0] dlc,
    input [63:0] d);
    @(posedge clk_sys_in);
    rx_valid_out <= 1'h1;
    rx_id_out <= id;
    rx_ext_out <= ext;
    rx_rtr_out <= rtr;
    rx_dlc_out <= dlc;
    rx_data_out <= d;
    @(posedge clk_sys_in);
    rx_valid_out <= 1'h0;
    // id, dlc and data fields no longer hold once the frame is gone
    rx_id_out <= ~id;
    rx_dlc_out <= ~dlc;
    rx_data_out <= ~d;
  endtask
endmodule

// *** tb/can_message_object_store_tb.sv ***
`timescale 1ns/1ps
`include "can_store_defines.vh"
`define CHK(g, x) begin checked = checked + 1; if ((g) !== (x)) begin \
  fail_count = fail_count + 1; \
  $display("Error %0t: got %h want %h", $time, g, x); end end

module can_message_object_store_tb;
  reg clk_sys_in = 1'h0, rstn_in = 1'h0, psel_in = 1'h0, e;
  reg penable_in = 1'h0, pwrite_in = 1'h0, fail_mode = 1'h0;
  reg bit_strobe_in = 1'h0, bit_sent_in = 1'h0, bit_seen_in = 1'h0;
  reg err_strobe_in = 1'h0, bus_off_in = 1'h0, error_passive_in = 1'h0;
  reg [2:0] err_code_in = 3'h0;
  reg [7:0] paddr_in = 8'h00, tx_err_count_in = 8'h00;
  reg [7:0] rx_err_count_in = 8'h00;
  reg [31:0] pwdata_in = 32'h0000_0000, q;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, rx_valid_in, rx_ext_in, rx_rtr_in;
  wire tx_valid_out, tx_ext_out, tx_rtr_out, tx_done_in, tx_fail_in;
  wire auto_retry_out;
  wire [28:0] rx_id_in, tx_id_out;
  wire [3:0] rx_dlc_in, tx_dlc_out;
  wire [63:0] rx_data_in, tx_data_out;
  integer fail_count = 0, checked = 0, i;
  always #5 clk_sys_in = ~clk_sys_in;
  can_message_object_store u_can_message_object_store (.clk_sys_in,
    .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .rx_valid_in, .rx_id_in,
    .rx_ext_in, .rx_rtr_in, .rx_dlc_in, .rx_data_in, .tx_valid_out,
    .tx_id_out, .tx_ext_out, .tx_rtr_out, .tx_dlc_out, .tx_data_out,
    .tx_done_in, .tx_fail_in, .auto_retry_out, .bit_strobe_in,
    .bit_sent_in, .bit_seen_in, .err_strobe_in, .err_code_in,
    .tx_err_count_in, .rx_err_count_in, .bus_off_in, .error_passive_in);
  can_bus_partner u_can_bus_partner (.clk_sys_in, .rstn_in,
    .tx_valid_in(tx_valid_out), .fail_mode_in(fail_mode),
    .tx_done_out(tx_done_in), .tx_fail_out(tx_fail_in),
    .rx_valid_out(rx_valid_in), .rx_id_out(rx_id_in),
    .rx_ext_out(rx_ext_in), .rx_rtr_out(rx_rtr_in),
    .rx_dlc_out(rx_dlc_in), .rx_data_out(rx_data_in));
  // ==========================================================
  // shared tasks
  task close_out;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task bound(input integer n);
    if (n >= 50) begin
      fail_count = fail_count + 1;
      close_out;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n = n + 1;
    end while (pready_out !== 1'h1 && n < 50);
    bound(n);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    apb(1'h0, a, 32'h0000_0000);
    `CHK(q, x)
  endtask
  task cmd(input [1:0] op, input c, input [5:0] n);
    apb(1'h1, `A_CMD, {19'h0_0000, c, 2'h0, op, 2'h0, n});
  endtask
  task oset(input [5:0] n, input [31:0] ctl, input [31:0] id);
    apb(1'h1, `A_OBJ_ID, id);
    apb(1'h1, `A_OBJ_MASK, 32'h0000_07F0);
    apb(1'h1, `A_OBJ_CTRL, ctl);
    apb(1'h1, `A_DATA_LO, 32'h4433_2211);
    apb(1'h1, `A_DATA_HI, 32'h8877_6655);
    cmd(2'h1, 1'h0, n);
  endtask
  task wtx(input v);
    integer n;
    n = 0;
    while (tx_valid_out !== v && n < 50) begin
      @(posedge clk_sys_in);
      n = n + 1;
    end
    bound(n);
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    rd(`A_RETRY, 32'h0000_0001);
    apb(1'h1, `A_RETRY, 32'h0000_0000);
    `CHK(auto_retry_out, 1'h0)
    rd(`A_RETRY, 32'h0000_0000);
    apb(1'h1, `A_RETRY, 32'h0000_0001);
    apb(1'h0, 8'h34, 32'h0000_0000);
    `CHK({e, q}, 33'h1_0000_0000)
    rd(`A_VALID, 32'h0000_0000);
    oset(6'h20, 32'h0000_0802, 32'h0000_0120);
    oset(6'h21, 32'h0000_0802, 32'h0000_0120);
    cmd(2'h1, 1'h0, 6'h00);
    rd(`A_VALID, 32'h8000_0000);
    cmd(2'h3, 1'h0, 6'h20);
    rd(`A_VALID, 32'h0000_0000);
  endtask
  task t_tx;
    oset(6'h03, 32'h0000_0808, 32'h0000_0123);
    rd(`A_TXPEND, 32'h0000_0004);
    rd(`A_VALID, 32'h0000_0004);
    wtx(1'h1);
    `CHK(tx_id_out, 29'h0000_0123)
    `CHK(tx_data_out, 64'h8877_6655_4433_2211)
    wtx(1'h0);
    // extended identifier keeps all 29 bits; no interrupt enabled here
    oset(6'h04, 32'h0000_0840, 32'h1ABC_DE12);
    wtx(1'h1);
    `CHK({tx_ext_out, tx_dlc_out, tx_id_out}, {5'h18, 29'h1ABC_DE12})
    wtx(1'h0);
    cmd(2'h3, 1'h0, 6'h04);
    rd(`A_TXPEND, 32'h0000_0000);
    rd(`A_STATUS, 32'h0000_0008);
    rd(`A_CAUSE, 32'h0000_0003);
    cmd(2'h2, 1'h1, 6'h03);
    rd(`A_CAUSE, 32'h0000_0000);
  endtask
  task t_rx;
    oset(6'h05, 32'h0000_0832, 32'h0000_0120);
    oset(6'h06, 32'h0000_0832, 32'h0000_0120);
    u_can_bus_partner.send(29'h125, 1'h0, 1'h0, 4'h8, 64'h1);
    rd(`A_FRESH, 32'h0000_0010);
    u_can_bus_partner.send(29'h12A, 1'h0, 1'h0, 4'h8, 64'h3333_4444);
    cmd(2'h2, 1'h0, 6'h05);
    rd(`A_OBJ_CTRL, 32'h0000_3832);
    rd(`A_DATA_LO, 32'h3333_4444);
    cmd(2'h2, 1'h0, 6'h05);
    rd(`A_OBJ_CTRL, 32'h0000_0832);
    rd(`A_CAUSE, `CAUSE_STATUS);
    // clear the success flags so the unmatched frame alone must set the receive flag
    apb(1'h0, `A_STATUS, 32'h0000_0000);
    u_can_bus_partner.send(29'h135, 1'h0, 1'h0, 4'h8, 64'h5);
    rd(`A_FRESH, 32'h0000_0000);
    rd(`A_STATUS, 32'h0000_0010);
    cmd(2'h3, 1'h0, 6'h05);
    rd(`A_VALID, 32'h0000_0024);
    rd(`A_INTPEND, 32'h0000_0000);
    u_can_bus_partner.send(29'h125, 1'h0, 1'h0, 4'h8, 64'h7);
    rd(`A_FRESH, 32'h0000_0020);
  endtask
  task t_err;
    apb(1'h0, `A_STATUS, 32'h0000_0000);
    for (i = 1; i < 7; i = i + 1) begin
      bit_strobe_in <= (i == 4 || i == 5);
      bit_sent_in <= (i == 4);
      bit_seen_in <= (i == 5);
      err_strobe_in <= !(i == 4 || i == 5);
      err_code_in <= i[2:0];
      @(posedge clk_sys_in);
      bit_strobe_in <= 1'h0;
      err_strobe_in <= 1'h0;
      rd(`A_STATUS, {29'h0, i[2:0]});
    end
    tx_err_count_in <= 8'h60;
    bus_off_in <= 1'h1;
    rd(`A_STATUS, 32'h0000_00C6);
    tx_err_count_in <= 8'h5F;
    rx_err_count_in <= 8'h60;
    bus_off_in <= 1'h0;
    error_passive_in <= 1'h1;
    rd(`A_STATUS, 32'h0000_0066);
    rx_err_count_in <= 8'h5F;
    rd(`A_STATUS, 32'h0000_0026);
  endtask
  task t_retry;
    fail_mode <= 1'h1;
    // a remote request object still carries the expected reply length
    oset(6'h01, 32'h0000_0409, 32'h0000_0055);
    wtx(1'h1);
    `CHK(tx_rtr_out, 1'h1)
    wtx(1'h0);
    wtx(1'h1);
    fail_mode <= 1'h0;
    wtx(1'h0);
    cmd(2'h2, 1'h0, 6'h01);
    rd(`A_OBJ_CTRL, 32'h0000_040A);
    apb(1'h1, `A_RETRY, 32'h0000_0000);
    fail_mode <= 1'h1;
    oset(6'h03, 32'h0000_0808, 32'h0000_0123);
    wtx(1'h1);
    wtx(1'h0);
    fail_mode <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    `CHK(tx_valid_out, 1'h0)
    rd(`A_TXPEND, 32'h0000_0000);
  endtask
  task t_remote;
    oset(6'h07, 32'h0000_0824, 32'h0000_0070);
    oset(6'h08, 32'h0000_0833, 32'h0000_0080);
    u_can_bus_partner.send(29'h77, 1'h0, 1'h1, 4'h8, 64'h0);
    wtx(1'h1);
    `CHK({tx_id_out, tx_rtr_out}, {29'h70, 1'h0})
    wtx(1'h0);
    u_can_bus_partner.send(29'h8F, 1'h0, 1'h1, 4'h8, 64'h0);
    rd(`A_FRESH, 32'h0000_00E0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'h1;
    @(posedge clk_sys_in);
    t_regs;
    t_tx;
    t_rx;
    t_err;
    t_retry;
    t_remote;
    close_out;
  end
endmodule
